// ==== slg_pkg.sv ====
package slg_pkg;
	// Clock and simulated train speeds
	localparam int CLK_HZ         = 50_000_000;
	localparam int SPEED_STD_KMH  = 100;
	localparam int SPEED_FOUR_KMH = 50;
	// Clock cycles per millimetre of travel at the standard speed
	localparam int CPM_STD_DEF = CLK_HZ / 10000 * 36 / SPEED_STD_KMH;

	// Lobe widths and centre spacings in millimetres
	localparam logic [11:0] W_SIDE_MM    = 12'hfa;
	localparam logic [11:0] W_MAIN_MM    = 12'h190;
	localparam logic [11:0] W4_FIRST_MM  = 12'h96;
	localparam logic [11:0] W4_SECOND_MM = 12'hc8;
	localparam logic [11:0] SP_FIXED_MM  = 12'hfa;
	localparam logic [11:0] SP_HALF_MM   = 12'h1f4;
	localparam logic [11:0] SP_ONE_MM    = 12'h3e8;
	localparam logic [11:0] SP_TWO_MM    = 12'h7d0;

	// Periodic link test
	localparam int LT_PERIOD_MS = 400;
	localparam int LT_CYC_DEF   = CLK_HZ / 1000 * LT_PERIOD_MS;
	localparam logic [4:0] LT_BITS = 5'h10;

	// Register map and control fields
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TELE0  = 8'h08;
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_SP_LSB     = 4;
	localparam int CTRL_START_BIT  = 8;
	localparam int CTRL_LT_EN_BIT  = 9;
	localparam logic [2:0] CTRL_MODE_RST = 3'h0;
	localparam logic [1:0] CTRL_SP_RST   = 2'h0;
	localparam logic       LT_EN_RST     = 1'h1;

	typedef enum logic [2:0] {
		MODE_THREE, MODE_PRE, MODE_SUC, MODE_FOUR, MODE_GROUP, MODE_REST
	} slg_mode_t;

	typedef enum logic [1:0] {ST_IDLE, ST_LOBE, ST_GAP} slg_st_t;

	typedef struct packed {
		logic data;
		logic lobe;
		logic test;
	} slg_link_t;

	typedef struct packed {
		slg_st_t           st;
		slg_mode_t         mode;
		logic [1:0]        sp;
		logic [1:0]        slot;
		logic [31:0]       cnt;
		logic [4:0]        bitpos;
		logic [31:0]       ltt;
		logic              lt_pend;
		logic              lt_on;
		logic [4:0]        lt_cnt;
		logic [2:0]        sync;
		logic [2:0]        ctrl_mode;
		logic [1:0]        ctrl_sp;
		logic              lt_en;
		logic              start_pend;
		logic [3:0][31:0]  tele;
		slg_link_t         link;
		logic [31:0]       rdata;
	} slg_state_t;
endpackage

// ==== slg_gen.sv ====
`timescale 1ns/100ps
// How it works
// - Lobe sends its telegram continuously, no gaps
// - Three-lobe side lobes both 0.25 m
// - Main lobe spans 0.4 m
// - Three-lobe spacings equal, test selects value
// - Spacing is 0.5, 1 or 2 m
// - Non four-lobe layouts run at 100 km/h
// - Preceding layout: no third lobe, side first
// - Succeeding layout: no first lobe, side after
// - Restrictive case uses preceding layout
// - Group case: two lobes, identical telegrams
// - Four-lobe first, second widths 0.15, 0.20 m
// - Four-lobe third 0.25 m, main 0.4 m
// - Four-lobe first spacings fixed 0.25 m
// - Four-lobe layout runs at 50 km/h
// - Each lobe carries its own telegram, except in the group case
// - Link tests sent periodically
// - Link tests only outside lobes
module slg_gen
	import slg_pkg::*;
#(
	parameter int P_CPM_STD = CPM_STD_DEF,
	parameter int P_LT_CYC  = LT_CYC_DEF
)(
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	input  wire logic        i_link_clk,
	output slg_link_t        o_link
);

	localparam logic [31:0] CPM_S = 32'(P_CPM_STD);
	localparam logic [31:0] CPM_F =
		32'(P_CPM_STD * SPEED_STD_KMH / SPEED_FOUR_KMH);
	localparam logic [31:0] LTC = 32'(P_LT_CYC);

	slg_state_t  r;
	slg_state_t  n;
	logic        rise;
	logic        four;
	logic        legal;
	slg_mode_t   m_new;
	logic [11:0] cur_mm;
	logic [1:0]  ti;
	logic [1:0]  last;

	// Width of each lobe slot per layout
	function automatic logic [11:0] lobe_mm(slg_mode_t m, logic [1:0] s);
		if (m == MODE_FOUR)
			return (s == 2'h0) ? W4_FIRST_MM : (s == 2'h1) ? W4_SECOND_MM :
				(s == 2'h2) ? W_SIDE_MM : W_MAIN_MM;
		else if (m == MODE_SUC)
			return (s == 2'h0) ? W_MAIN_MM : W_SIDE_MM;
		else if (m == MODE_THREE)
			return (s == 2'h1) ? W_MAIN_MM : W_SIDE_MM;
		else
			return (s == 2'h0) ? W_SIDE_MM : W_MAIN_MM;
	endfunction

	// Index of the last lobe slot; absent lobes are never reached
	function automatic logic [1:0] last_slot(slg_mode_t m);
		if (m == MODE_FOUR)
			return 2'h3;
		else if (m == MODE_THREE)
			return 2'h2;
		else
			return 2'h1;
	endfunction

	// Selectable spacing; code 3 also gives the longest spacing
	function automatic logic [11:0] sel_mm(logic [1:0] sp);
		return (sp == 2'h0) ? SP_HALF_MM :
			(sp == 2'h1) ? SP_ONE_MM : SP_TWO_MM;
	endfunction

	// Edge-to-edge gap: centre spacing less two half widths
	function automatic logic [11:0] gap_mm(slg_mode_t m, logic [1:0] sp,
		logic [1:0] s);
		logic [12:0] half;
		logic [11:0] c;
		half = (13'(lobe_mm(m, s)) + 13'(lobe_mm(m, s + 2'h1))) >> 1;
		c = (m == MODE_FOUR && s != 2'h2) ? SP_FIXED_MM : sel_mm(sp);
		return c - half[11:0];
	endfunction

	// Distance to cycles at the layout's speed, never below one
	function automatic logic [31:0] cyc(logic [11:0] mm, logic f);
		logic [31:0] c;
		c = 32'(mm) * (f ? CPM_F : CPM_S);
		return (c == 32'h0) ? 32'h1 : c;
	endfunction

	// Telegram register feeding each slot
	function automatic logic [1:0] tele_idx(slg_mode_t m, logic [1:0] s);
		if (m == MODE_SUC)
			return s + 2'h1;
		else if (m == MODE_GROUP && s == 2'h0)
			return 2'h1;
		else
			return s;
	endfunction

	assign rise   = r.sync[1] & ~r.sync[2];
	assign four   = (r.mode == MODE_FOUR);
	assign legal  = (r.ctrl_mode <= MODE_REST);
	assign m_new  = slg_mode_t'(r.ctrl_mode);
	assign cur_mm = lobe_mm(r.mode, r.slot);
	assign ti     = tele_idx(r.mode, r.slot);
	assign last   = last_slot(r.mode);

	// Next state: link test, lobe sequencer, then register access
	always_comb
	begin
		n = r;
		n.rdata = 32'h0;
		n.sync = {r.sync[1:0], i_link_clk};
		// A link test may only start while no sequence runs
		if (r.lt_pend && r.st == ST_IDLE && !r.lt_on)
		begin
			n.lt_on = 1'b1;
			n.lt_pend = 1'b0;
			n.lt_cnt = 5'h0;
		end
		if (r.lt_en)
		begin
			if (r.ltt >= LTC - 32'h1)
			begin
				n.ltt = 32'h0;
				n.lt_pend = 1'b1;
			end
			else
				n.ltt = r.ltt + 32'h1;
		end
		if (r.lt_on && rise)
		begin
			if (r.lt_cnt == LT_BITS)
				n.lt_on = 1'b0;
			else
			begin
				n.link.data = ~r.lt_cnt[0];
				n.lt_cnt = r.lt_cnt + 5'h1;
			end
		end
		unique case (r.st)
			ST_IDLE:
			begin
				// A test ends a cycle before any lobe may rise
				if (r.start_pend && !r.lt_on && !n.lt_on)
				begin
					n.start_pend = 1'b0;
					if (legal)
					begin
						n.mode = m_new;
						n.sp = r.ctrl_sp;
						n.slot = 2'h0;
						n.bitpos = 5'h1;
						n.link.data = r.tele[tele_idx(m_new, 2'h0)][0];
						n.cnt = cyc(lobe_mm(m_new, 2'h0),
							m_new == MODE_FOUR) - 32'h1;
						n.st = ST_LOBE;
					end
				end
			end
			ST_LOBE:
			begin
				if (rise)
				begin
					n.link.data = r.tele[ti][r.bitpos];
					n.bitpos = r.bitpos + 5'h1;
				end
				if (r.cnt != 32'h0)
					n.cnt = r.cnt - 32'h1;
				else if (r.slot == last)
					n.st = ST_IDLE;
				else
				begin
					n.st = ST_GAP;
					n.cnt = cyc(gap_mm(r.mode, r.sp, r.slot), four) - 32'h1;
				end
			end
			ST_GAP:
			begin
				if (r.cnt != 32'h0)
					n.cnt = r.cnt - 32'h1;
				else
				begin
					n.slot = r.slot + 2'h1;
					n.bitpos = 5'h1;
					n.link.data = r.tele[tele_idx(r.mode, n.slot)][0];
					n.cnt = cyc(lobe_mm(r.mode, n.slot), four) - 32'h1;
					n.st = ST_LOBE;
				end
			end
		endcase
		n.link.lobe = (n.st == ST_LOBE);
		n.link.test = n.lt_on;
		// Nothing is sent between lobes
		if (!n.link.lobe && !n.lt_on)
			n.link.data = 1'b0;
		// Writes after the sequencer so a new start is never lost
		if (i_wr)
		begin
			if (i_addr == REG_CTRL)
			begin
				n.ctrl_mode = i_wdata[CTRL_MODE_LSB +: 3];
				n.ctrl_sp = i_wdata[CTRL_SP_LSB +: 2];
				n.lt_en = i_wdata[CTRL_LT_EN_BIT];
				if (i_wdata[CTRL_START_BIT])
					n.start_pend = 1'b1;
			end
			for (int i = 0; i < 4; i++)
				if (i_addr == REG_TELE0 + 8'(4 * i))
					n.tele[i] = i_wdata;
		end
		// Read data stands in the cycle after the strobe only
		if (i_rd)
		begin
			if (i_addr == REG_CTRL)
				n.rdata = {22'h0, r.lt_en, 1'b0, 2'h0, r.ctrl_sp,
					1'b0, r.ctrl_mode};
			else if (i_addr == REG_STATUS)
				n.rdata = {24'h0, r.slot, 2'(r.st), r.start_pend,
					r.lt_pend, r.lt_on, r.st != ST_IDLE};
			for (int i = 0; i < 4; i++)
				if (i_addr == REG_TELE0 + 8'(4 * i))
					n.rdata = r.tele[i];
		end
	end

	// State register
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			r <= '0;
			r.st <= ST_IDLE;
			r.mode <= MODE_THREE;
			r.ctrl_mode <= CTRL_MODE_RST;
			r.ctrl_sp <= CTRL_SP_RST;
			r.lt_en <= LT_EN_RST;
		end
		else
			r <= n;
	end

	assign o_rdata = r.rdata;
	assign o_link  = r.link;

	// Helper: measured lobe length against the loaded length
	logic [31:0] act_cnt;
	logic [31:0] exp_r;

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			act_cnt <= 32'h0;
			exp_r <= 32'h0;
		end
		else
		begin
			act_cnt <= o_link.lobe ? act_cnt + 32'h1 : 32'h0;
			if (r.st != ST_LOBE && n.st == ST_LOBE)
				exp_r <= n.cnt + 32'h1;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	property p_len;
		$fell(o_link.lobe) |-> act_cnt == exp_r;
	endproperty
	a_len: assert property (p_len) else $error("lobe length wrong");

	property p_cont;
		o_link.lobe && $past(o_link.lobe) && $changed(o_link.data)
			|-> $past(rise);
	endproperty
	a_cont: assert property (p_cont) else $error("lobe data glitch");

	property p_idle;
		!o_link.lobe && !o_link.test |-> !o_link.data;
	endproperty
	a_idle: assert property (p_idle) else $error("data between lobes");

	property p_lt_out;
		o_link.test |-> !o_link.lobe ##1 !o_link.lobe;
	endproperty
	a_lt_out: assert property (p_lt_out) else $error("test in lobe");

	property p_std;
		$rose(o_link.lobe) && r.mode != MODE_FOUR
			|-> exp_r == 32'(cur_mm) * CPM_S;
	endproperty
	a_std: assert property (p_std) else $error("std speed wrong");

	property p_four;
		$rose(o_link.lobe) && r.mode == MODE_FOUR
			|-> exp_r == 32'(cur_mm) * CPM_F;
	endproperty
	a_four: assert property (p_four) else $error("four speed wrong");

	property p_pre;
		r.st == ST_LOBE && r.mode inside {MODE_PRE, MODE_REST, MODE_GROUP}
			|-> r.slot <= 2'h1 && cur_mm == (r.slot == 2'h0 ? 250 : 400);
	endproperty
	a_pre: assert property (p_pre) else $error("preceding layout");

	property p_suc;
		r.st == ST_LOBE && r.mode == MODE_SUC
			|-> ti == r.slot + 2'h1 && cur_mm == (r.slot == 2'h0 ? 400 : 250);
	endproperty
	a_suc: assert property (p_suc) else $error("succeeding layout");

	property p_group;
		r.st == ST_LOBE && r.mode == MODE_GROUP |-> ti == 2'h1;
	endproperty
	a_group: assert property (p_group) else $error("group telegram");

	property p_gap4;
		r.st == ST_GAP && $past(r.st) == ST_LOBE && four && r.slot < 2'h2
			|-> r.cnt == (r.slot == 2'h0 ? 75 : 25) * CPM_F - 32'h1;
	endproperty
	a_gap4: assert property (p_gap4) else $error("four-lobe gap");

	property p_ltper;
		$rose(r.lt_pend) |-> $past(r.ltt) == LTC - 32'h1;
	endproperty
	a_ltper: assert property (p_ltper) else $error("test period");

	c_four: cover property (r.mode == MODE_FOUR && r.slot == 2'h3
		&& r.st == ST_LOBE);
	c_three: cover property (r.mode == MODE_THREE && $fell(o_link.lobe)
		&& r.st == ST_IDLE);
	c_lt: cover property ($fell(o_link.test));
	c_group: cover property (r.mode == MODE_GROUP && $rose(o_link.lobe));
endmodule

// ==== slg_rx.sv ====
`timescale 1ns/100ps
module slg_rx
	import slg_pkg::*;
(
	input  wire logic      i_clk,
	input  wire slg_link_t i_link,
	input  wire logic      i_clear
);
	int         nl;
	int         nt;
	int         run;
	int         bad;
	int         edg;
	int         len[8];
	int         gap[8];
	logic [1:0] sig[8];
	slg_link_t  prv;
	// Receiver view: lobe and gap lengths, content summary, test shape
	always @(posedge i_clk)
	begin
		if (i_link.lobe && i_link.test)
			bad = bad + 1;
		if (!i_link.lobe && !i_link.test && i_link.data !== 1'b0)
			bad = bad + 1;
		if (i_link.lobe && !prv.lobe)
		begin
			gap[nl] = run;
			run = 0;
			sig[nl] = {i_link.data, i_link.data};
		end
		// Keeps OR and AND of data, so one zero bit shows in AND
		if (i_link.lobe)
			sig[nl] = {sig[nl][1] | i_link.data, sig[nl][0] & i_link.data};
		if (!i_link.lobe && prv.lobe && nl < 7)
		begin
			len[nl] = run;
			run = 0;
			nl = nl + 1;
		end
		if (i_link.test && !prv.test)
			edg = 0;
		if (i_link.test && i_link.data && !prv.data)
			edg = edg + 1;
		if (!i_link.test && prv.test)
		begin
			nt = nt + 1;
			if (edg != 8)
				bad = bad + 1;
		end
		run = run + 1;
		prv = i_link;
		// Clear last, so slips seen before reset settles are forgotten
		if (i_clear)
		begin
			nl = 0;
			nt = 0;
			bad = 0;
		end
	end
endmodule

// ==== test_slg_gen.sv ====
`timescale 1ns/100ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
	fails++; $display("unexpected %s exp %0h got %0h", n, e, a); end end
module test_slg_gen
	import slg_pkg::*;
;
	localparam int CPM = 2;
	logic        i_clk      = 1'b0;
	logic        i_reset_n  = 1'b0;
	logic [7:0]  i_addr     = 8'h00;
	logic [31:0] i_wdata    = 32'h0;
	logic        i_wr       = 1'b0;
	logic        i_rd       = 1'b0;
	logic        i_link_clk = 1'b0;
	logic        clr        = 1'b1;
	logic [31:0] o_rdata;
	slg_link_t   o_link;
	int          fails      = 0;
	int          cmp_count  = 0;

	slg_gen #(.P_CPM_STD(CPM), .P_LT_CYC(2000)) i_slg_gen (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_link_clk(i_link_clk), .o_link(o_link));
	slg_rx i_slg_rx (.i_clk(i_clk), .i_link(o_link), .i_clear(clr));

	// Link clock edges fall on main clock falling edges, never rising
	always #10 i_clk = ~i_clk;
	always #80 i_link_clk = ~i_link_clk;

	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe edge
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 `CHK("rdata", e, o_rdata)
	endtask

	// Start one layout; w in mm, c centre spacing in mm, g content code
	task automatic seq(input logic [2:0] m, input logic [1:0] s,
		input int n, input int w[4], input int c[4], input int g[4]);
		int k;
		int q;
		int gx;
		q = (m == MODE_FOUR) ? 2 * CPM : CPM;
		clr <= 1'b1;
		@(posedge i_clk);
		clr <= 1'b0;
		wr(REG_CTRL, 32'h300 | {26'h0, s, 1'b0, m});
		for (k = 0; k < 40000 && i_slg_rx.nl < n; k++)
			@(posedge i_clk);
		// Step off the edge so the model's counts have settled
		#1;
		`CHK("lobes", n, i_slg_rx.nl)
		for (k = 0; k < n; k++)
		begin
			`CHK("width", w[k] * q, i_slg_rx.len[k])
			`CHK("content", 2'(g[k]), i_slg_rx.sig[k])
			if (k > 0)
			begin
				gx = (c[k] - w[k-1]/2 - w[k]/2) * q;
				`CHK("gap", gx, i_slg_rx.gap[k])
			end
		end
		`CHK("slips", 0, i_slg_rx.bad)
	endtask

	function automatic int spmm(input logic [1:0] s);
		return (s == 2'h0) ? 500 : (s == 2'h1) ? 1000 : 2000;
	endfunction

	task automatic t_regs();
		rd(REG_CTRL, 32'h200);
		wr(REG_CTRL, 32'h15);
		rd(REG_CTRL, 32'h15);
		wr(8'h40, 32'h1234);
		rd(8'h40, 32'h0);
		wr(REG_TELE0, 32'h55555555);
		wr(REG_TELE0 + 8'h4, 32'h0);
		wr(REG_TELE0 + 8'h8, 32'hffffffff);
		wr(REG_TELE0 + 8'hc, 32'h55555555);
		rd(REG_TELE0 + 8'h8, 32'hffffffff);
	endtask

	task automatic t_three(input logic [1:0] s);
		int d;
		d = spmm(s);
		seq(MODE_THREE, s, 3, '{250, 400, 250, 0}, '{0, d, d, 0},
			'{2, 0, 3, 0});
	endtask

	task automatic t_sides();
		seq(MODE_PRE, 1, 2, '{250, 400, 0, 0}, '{0, 1000, 0, 0},
			'{2, 0, 0, 0});
		seq(MODE_SUC, 0, 2, '{400, 250, 0, 0}, '{0, 500, 0, 0},
			'{0, 3, 0, 0});
		seq(MODE_GROUP, 0, 2, '{250, 400, 0, 0}, '{0, 500, 0, 0},
			'{0, 0, 0, 0});
		seq(MODE_REST, 2, 2, '{250, 400, 0, 0}, '{0, 2000, 0, 0},
			'{2, 0, 0, 0});
	endtask

	task automatic t_four();
		seq(MODE_FOUR, 3, 4, '{150, 200, 250, 400}, '{0, 250, 250, 2000},
			'{2, 0, 3, 2});
	endtask

	// An illegal layout code must not start anything; tests keep running
	task automatic t_idle();
		clr <= 1'b1;
		@(posedge i_clk);
		clr <= 1'b0;
		wr(REG_CTRL, 32'h306);
		repeat (2500) @(posedge i_clk);
		#1;
		`CHK("no lobe", 0, i_slg_rx.nl)
		`CHK("tests", 1'b1, i_slg_rx.nt > 0)
		`CHK("slips", 0, i_slg_rx.bad)
	endtask

	initial
	begin
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1'b1;
		clr <= 1'b0;
		t_regs();
		t_three(2'h0);
		t_three(2'h2);
		t_sides();
		t_four();
		t_idle();
		close_out();
	end

	// Whole run is near 40000 cycles; cut off well beyond that
	initial
	begin
		#1_800_000;
		fails++;
		close_out();
	end
endmodule
